/* File: core/sram_ctrl_end.sv */
// controller end: makes the link clocks, queues requests, drives commands and write beats
`timescale 1ns/100ps
module sram_ctrl_end #(
    parameter int DATA_W = 18,
    parameter int LANES = 2,
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // link to the device
    ddr_link_if.controller link,
    // configuration
    input wire logic useOutClk,
    // requests
    input wire logic reqValid,
    output logic reqReady,
    input wire logic reqWrite,
    input wire logic [ADDR_W-1:0] reqAddr,
    input wire logic [DATA_W-1:0] reqData0,
    input wire logic [DATA_W-1:0] reqData1,
    input wire logic [LANES-1:0] reqMask0N,
    input wire logic [LANES-1:0] reqMask1N,
    // read answers
    output logic rspValid,
    output logic [DATA_W-1:0] rspData0,
    output logic [DATA_W-1:0] rspData1
);
    localparam int FW = 1 + ADDR_W + 2 * DATA_W + 2 * LANES;

    if (DATA_W % LANES != 0 || ADDR_W < 2) begin : g_bad
        $error("sram_ctrl_end: data width must split evenly into lanes");
    end

    typedef struct packed {
        logic [DATA_W-1:0] d0;
        logic [DATA_W-1:0] d1;
        logic [LANES-1:0] m0;
        logic [LANES-1:0] m1;
    } wbeats_s;

    typedef struct packed {
        logic [1:0] ph;
        logic kClk;
        logic kClkN;
        logic cClk;
        logic cClkN;
        logic strobeN;
        logic rnw;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] mask;
        logic [DATA_W-1:0] dq;
        logic oe;
        sram_pkg::cmd_e issued;
        sram_pkg::cmd_e sampled;
        sram_pkg::cmd_e aged;
        wbeats_s isW;
        wbeats_s smW;
        logic beat2Pend;
        logic [1:0] gap;
        logic capPend;
        logic rspValid;
        logic [DATA_W-1:0] rsp0;
        logic [DATA_W-1:0] rsp1;
    } state_s;

    state_s s;
    state_s n;
    logic headValid;
    logic headReady;
    logic [FW-1:0] head;
    logic headWrite;
    logic [ADDR_W-1:0] headAddr;
    wbeats_s headW;
    logic [1:0] phNext;

    // the queue stalls requests while the link waits on turnaround slots
    sync_fifo #(
        .WIDTH(FW),
        .DEPTH(sram_pkg::FIFO_DEPTH)
    ) u_queue (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .inValid(reqValid),
        .inReady(reqReady),
        .inData({reqWrite, reqAddr, reqData0, reqData1, reqMask0N, reqMask1N}),
        .outValid(headValid),
        .outReady(headReady),
        .outData(head)
    );

    assign {headWrite, headAddr, headW} = head;
    assign link.kClk = s.kClk;
    assign link.kClkN = s.kClkN;
    assign link.cClk = s.cClk;
    assign link.cClkN = s.cClkN;
    assign link.commandLoadStrobeN = s.strobeN;
    assign link.readNotWrite = s.rnw;
    assign link.addr = s.addr;
    assign link.byteLaneMaskN = s.mask;
    assign link.dqFromCtrl = s.dq;
    assign link.ctrlOe = s.oe;
    assign rspValid = s.rspValid;
    assign rspData0 = s.rsp0;
    assign rspData1 = s.rsp1;

    // R20 a write waits out the read beats still on the bus
    assign headReady = (s.ph == sram_pkg::PH_K_HIGH) & ~(headWrite & (s.gap != 2'h0));

    always_comb begin
        n = s;
        n.rspValid = 1'b0;
        phNext = s.ph + 2'h1;
        n.ph = phNext;
        n.kClk = (phNext == sram_pkg::PH_K_HIGH) | (phNext == sram_pkg::PH_K_HIGH + 2'h1);
        n.kClkN = ~n.kClk;
        // output clocks trail k by one cycle, or sit tied high
        n.cClk = useOutClk ? s.kClk : 1'b1;
        n.cClkN = useOutClk ? s.kClkN : 1'b1;

        if (s.ph == sram_pkg::PH_K_HIGH) begin
            // R2 one command slot per k cycle, deselect when idle
            n.sampled = s.issued;
            n.aged = s.sampled;
            n.smW = s.isW;
            if (headValid && headReady) begin
                // R6 strobe low, rw picks the operation
                n.strobeN = 1'b0;
                n.rnw = ~headWrite;
                n.addr = headAddr;
                n.isW = headW;
                n.issued = headWrite ? sram_pkg::CMD_WRITE : sram_pkg::CMD_READ;
                n.gap = headWrite ? (s.gap == 2'h0 ? 2'h0 : s.gap - 2'h1) : sram_pkg::TURN_GAP;
            end else begin
                n.strobeN = 1'b1;
                n.issued = sram_pkg::CMD_DESEL;
                n.gap = (s.gap == 2'h0) ? 2'h0 : s.gap - 2'h1;
            end
            // R10 second write beat for the k-complement edge
            if (s.beat2Pend) begin
                n.dq = s.smW.d1;
                n.mask = s.smW.m1;
                n.beat2Pend = 1'b0;
            end
            // R1 first read beat, two k cycles after sampling
            if (s.aged == sram_pkg::CMD_READ) begin
                n.rsp0 = link.dq;
                n.capPend = 1'b1;
            end
        end

        if (s.ph == sram_pkg::PH_KN_HIGH) begin
            // R9 R11 first write beat with its own mask before the next k rise
            if (s.sampled == sram_pkg::CMD_WRITE) begin
                n.dq = s.smW.d0;
                n.mask = s.smW.m0;
                n.oe = 1'b1;
                n.beat2Pend = 1'b1;
            end else begin
                n.oe = 1'b0;
            end
            if (s.capPend) begin
                n.rsp1 = link.dq;
                n.capPend = 1'b0;
                n.rspValid = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            s.ph <= 2'h3;
            s.kClkN <= 1'b1;
            s.cClk <= 1'b1;
            s.cClkN <= 1'b1;
            s.strobeN <= 1'b1;
            s.mask <= '1;
        end else begin
            s <= n;
        end
    end
endmodule

/* File: core/sram_device_end.sv */
// device end: burst-of-two common-i/o ddr sram with lane masks and impedance stepping
`timescale 1ns/100ps
// Behaviour
// R1 - every read or write moves two beats
// R2 - controller may issue one command per cycle
// R3 - deselect pipelined like a read
// R4 - strobe high ignores rw and address
// R5 - command pins sampled on k rise only
// R6 - strobe high deselect, else rw picks
// R7 - read beat one on output-complement rise
// R8 - read beat two on next output rise
// R9 - write beat one at next k rise
// R10 - write beat two on k-complement rise
// R11 - each beat carries its own mask
// R12 - high mask keeps that lane unchanged
// R13 - controller may mask any lane, any beat
// R14 - one address load covers two beats
// R15 - nibble variant masks four-bit lanes alike
// R16 - no enabled beat aborts whole write
// R17 - output clocks tied high use k clocks
// R18 - periodic impedance step toward optimum
// R19 - variants without lowest bit force zero
// R20 - controller leaves turnaround between read, write
module sram_device_end #(
    parameter int DATA_W = 18,
    parameter int LANES = 2,
    parameter int ADDR_W = 8,
    parameter bit HAS_A0 = 1'b1,
    parameter int IMP_W = 5
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // link to the controller
    ddr_link_if.device link,
    // impedance tuning
    input wire logic [IMP_W-1:0] impedanceReferencePin,
    output logic [IMP_W-1:0] driveCode
);
    localparam int LANE_W = DATA_W / LANES;
    localparam int CNT_W = $clog2(sram_pkg::IMP_INTERVAL_CYC + 1);
    localparam logic [CNT_W-1:0] IMP_RELOAD = CNT_W'(sram_pkg::IMP_INTERVAL_CYC - 1);

    if (LANES * LANE_W != DATA_W || ADDR_W < 2 || IMP_W < 2 || sram_pkg::IMP_INTERVAL_CYC < 1) begin : g_bad
        $error("sram_device_end: data width must split evenly into lanes");
    end

    typedef struct packed {
        logic kPrev;
        logic knPrev;
        logic cPrev;
        logic cnPrev;
        sram_pkg::cmd_e stage1;
        sram_pkg::cmd_e stage2;
        logic [ADDR_W-1:0] addr1;
        logic [DATA_W-1:0] rd0;
        logic [DATA_W-1:0] rd1;
        logic [DATA_W-1:0] rdHold;
        logic rdBeat2;
        logic wrPend;
        logic [ADDR_W-1:0] wrAddr;
        logic [DATA_W-1:0] wr0;
        logic [LANES-1:0] wm0;
        logic [DATA_W-1:0] dqOut;
        logic dqOe;
        logic [IMP_W-1:0] zq1;
        logic [IMP_W-1:0] zq2;
        logic [IMP_W-1:0] zq3;
        logic [IMP_W-1:0] zqTarget;
        logic [IMP_W-1:0] drive;
        logic [CNT_W-1:0] impCnt;
    } state_s;

    state_s s;
    state_s n;
    logic [DATA_W-1:0] mem [2**ADDR_W];
    logic kRise;
    logic knRise;
    logic outRise;
    logic outFall;
    logic commitEn;

    // beat address of a burst; narrow parts have no lowest bit to start from
    function automatic logic [ADDR_W-1:0] beatAddr(input logic [ADDR_W-1:0] base, input logic second);
        logic [ADDR_W-1:0] a;
        a = base;
        // R19 lowest bit forced
        if (!HAS_A0) begin
            a[0] = 1'b0;
        end
        a[0] = a[0] ^ second;
        return a;
    endfunction

    assign link.dqFromDev = s.dqOut;
    assign link.devOe = s.dqOe;
    assign driveCode = s.drive;

    always_comb begin
        n = s;
        // R5 edges of the k clock pair; commands take the true k rise only
        kRise = link.kClk & ~s.kPrev;
        knRise = link.kClkN & ~s.knPrev;
        // R17 tied-high output clocks fall back to k
        if (link.cClk & link.cClkN) begin
            outRise = kRise;
            outFall = knRise;
        end else begin
            outRise = link.cClk & ~s.cPrev;
            outFall = link.cClkN & ~s.cnPrev;
        end
        n.kPrev = link.kClk;
        n.knPrev = link.kClkN;
        n.cPrev = link.cClk;
        n.cnPrev = link.cClkN;

        if (kRise) begin
            // R4 R6 strobe high is deselect, rw and address ignored
            if (link.commandLoadStrobeN) begin
                n.stage1 = sram_pkg::CMD_DESEL;
            end else begin
                n.stage1 = link.readNotWrite ? sram_pkg::CMD_READ : sram_pkg::CMD_WRITE;
                n.addr1 = link.addr;
            end
            // R3 deselect travels the same two stages as a read
            n.stage2 = s.stage1;
            // R14 one load fetches both beats
            if (s.stage1 == sram_pkg::CMD_READ) begin
                n.rd0 = mem[beatAddr(s.addr1, 1'b0)];
                n.rd1 = mem[beatAddr(s.addr1, 1'b1)];
            end
            // R9 R11 first write beat with its own mask
            if (s.stage1 == sram_pkg::CMD_WRITE) begin
                n.wrPend = 1'b1;
                n.wrAddr = s.addr1;
                n.wr0 = link.dq;
                n.wm0 = link.byteLaneMaskN;
            end
        end

        // R10 R16 second beat completes the write unless both beats disabled
        commitEn = knRise & s.wrPend & (~&s.wm0 | ~&link.byteLaneMaskN);
        if (knRise) begin
            n.wrPend = 1'b0;
        end

        // R7 R1 first read beat, or release the bus
        if (outFall) begin
            if (s.stage2 == sram_pkg::CMD_READ) begin
                n.dqOut = s.rd0;
                n.rdHold = s.rd1;
                n.dqOe = 1'b1;
                n.rdBeat2 = 1'b1;
            end else begin
                n.dqOe = 1'b0;
            end
        end
        // R8 second beat from a copy, the next read may already refill
        if (outRise && s.rdBeat2) begin
            n.dqOut = s.rdHold;
            n.rdBeat2 = 1'b0;
        end

        // reference pin is asynchronous: third stage must agree with second
        n.zq1 = impedanceReferencePin;
        n.zq2 = s.zq1;
        n.zq3 = s.zq2;
        if (s.zq2 == s.zq3) begin
            n.zqTarget = s.zq3;
        end
        // R18 interval count, then a single step
        if (s.impCnt == '0) begin
            n.impCnt = IMP_RELOAD;
            if (s.drive < s.zqTarget) begin
                n.drive = s.drive + IMP_W'(1);
            end else if (s.drive > s.zqTarget) begin
                n.drive = s.drive - IMP_W'(1);
            end
        end else begin
            n.impCnt = s.impCnt - CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            // prev levels start high so a clock already high is no edge
            s.kPrev <= 1'b1;
            s.knPrev <= 1'b1;
            s.cPrev <= 1'b1;
            s.cnPrev <= 1'b1;
            s.drive <= IMP_W'(sram_pkg::IMP_CODE_RESET);
            s.zqTarget <= IMP_W'(sram_pkg::IMP_CODE_RESET);
            s.impCnt <= IMP_RELOAD;
            // sync stages start at the reset code so no zero target follows reset
            s.zq1 <= IMP_W'(sram_pkg::IMP_CODE_RESET);
            s.zq2 <= IMP_W'(sram_pkg::IMP_CODE_RESET);
            s.zq3 <= IMP_W'(sram_pkg::IMP_CODE_RESET);
        end else begin
            s <= n;
        end
    end

    // contents have no reset, as in the real array
    always_ff @(posedge ref_clk) begin
        if (commitEn) begin
            for (int l = 0; l < LANES; l++) begin
                // R12 R15 masked lanes keep stored data
                if (!s.wm0[l]) begin
                    mem[beatAddr(s.wrAddr, 1'b0)][l*LANE_W +: LANE_W] <= s.wr0[l*LANE_W +: LANE_W];
                end
                if (!link.byteLaneMaskN[l]) begin
                    mem[beatAddr(s.wrAddr, 1'b1)][l*LANE_W +: LANE_W] <= link.dq[l*LANE_W +: LANE_W];
                end
            end
        end
    end
endmodule

/* File: core/sync_fifo.sv */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module sync_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData
);
    localparam int PW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin : g_bad
        $error("sync_fifo: depth must be a power of two of at least 2");
    end

    typedef struct packed {
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [PW:0] count;
        logic notFull;
        logic notEmpty;
    } state_s;

    state_s s;
    state_s n;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign push = inValid & s.notFull;
    assign pop = outReady & s.notEmpty;
    assign inReady = s.notFull;
    assign outValid = s.notEmpty;
    assign outData = mem[s.rp];

    always_comb begin
        n = s;
        if (push) begin
            n.wp = s.wp + PW'(1);
        end
        if (pop) begin
            n.rp = s.rp + PW'(1);
        end
        n.count = s.count + (PW+1)'(push) - (PW+1)'(pop);
        // flags kept registered so the fill-side ready is a clean flop
        n.notFull = (n.count != (PW+1)'(DEPTH));
        n.notEmpty = (n.count != '0);
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            s.notFull <= 1'b1;
        end else begin
            s <= n;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[s.wp] <= inData;
        end
    end
endmodule

/* File: shared/ddr_link_if.sv */
// pin-level link between the sram device end and its controller
`timescale 1ns/100ps
interface ddr_link_if #(
    parameter int DATA_W = 18,
    parameter int LANES = 2,
    parameter int ADDR_W = 8
);
    logic kClk;
    logic kClkN;
    logic cClk;
    logic cClkN;
    logic commandLoadStrobeN;
    logic readNotWrite;
    logic [ADDR_W-1:0] addr;
    logic [LANES-1:0] byteLaneMaskN;
    logic [DATA_W-1:0] dqFromCtrl;
    logic ctrlOe;
    logic [DATA_W-1:0] dqFromDev;
    logic devOe;
    logic [DATA_W-1:0] dq;

    // shared data wire: whoever enables drives it, idle reads zero
    assign dq = (ctrlOe ? dqFromCtrl : '0) | (devOe ? dqFromDev : '0);

    modport device (
        input kClk, kClkN, cClk, cClkN, commandLoadStrobeN, readNotWrite, addr, byteLaneMaskN, dq,
        output dqFromDev, devOe
    );
    modport controller (
        output kClk, kClkN, cClk, cClkN, commandLoadStrobeN, readNotWrite, addr, byteLaneMaskN,
        output dqFromCtrl, ctrlOe,
        input dq
    );
endinterface

/* File: shared/sram_pkg.sv */
// shared constants and types for the burst-of-two ddr sram link
package sram_pkg;
    localparam int CLK_PERIOD_NS = 40;
    // impedance re-evaluation interval
    localparam int IMP_INTERVAL_NS = 2000;
    localparam int IMP_INTERVAL_CYC = IMP_INTERVAL_NS / CLK_PERIOD_NS;
    localparam int IMP_CODE_RESET = 8;
    // divider phases: k rises entering phase 0, k-complement entering phase 2
    localparam logic [1:0] PH_K_HIGH = 2'h0;
    localparam logic [1:0] PH_KN_HIGH = 2'h2;
    // deselect slots forced between a read and a following write
    localparam logic [1:0] TURN_GAP = 2'h2;
    localparam int FIFO_DEPTH = 4;
    typedef enum logic [1:0] {
        CMD_DESEL = 2'h0,
        CMD_READ = 2'h1,
        CMD_WRITE = 2'h3
    } cmd_e;
endpackage

/* File: verification/sram_link_props.sv */
// link-level checker for the controller and device ends
`timescale 1ns/100ps
module sram_link_props #(
    parameter int IMP_W = 5
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // link clocks
    input wire logic kClk,
    input wire logic kClkN,
    input wire logic cClk,
    input wire logic cClkN,
    // command and bus enables
    input wire logic commandLoadStrobeN,
    input wire logic readNotWrite,
    input wire logic ctrlOe,
    input wire logic devOe,
    // impedance setting
    input wire logic [IMP_W-1:0] driveCode
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    logic kPrev;
    logic readCmd;
    logic writeCmd;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            kPrev <= 1'h0;
        end else begin
            kPrev <= kClk;
        end
    end
    // a command is new only in the second half of k high
    assign readCmd = kClk && kPrev && !commandLoadStrobeN && readNotWrite;
    assign writeCmd = kClk && kPrev && !commandLoadStrobeN && !readNotWrite;

    chk_k_pair: assert property (kClkN == !kClk)
        else $error("k clocks not complementary");
    chk_k_period: assert property ($rose(kClk) |-> kClk[*2] ##1 !kClk[*2] ##1 kClk)
        else $error("k clock period wrong");
    chk_out_clk: assert property (!(cClk && cClkN) |-> cClk == $past(kClk) && cClkN == $past(kClkN))
        else $error("output clocks do not follow k");
    chk_cmd_stable: assert property ($changed(commandLoadStrobeN) || $changed(readNotWrite) |-> kClk && kPrev)
        else $error("command lines changed mid cycle");
    chk_read_oe_k: assert property (readCmd && cClk && cClkN |-> ##10 devOe[*4])
        else $error("read beats late in k mode");
    chk_read_oe_c: assert property (readCmd && !(cClk && cClkN) |-> ##11 devOe[*4])
        else $error("read beats late in c mode");
    // driver starts only after a read
    chk_desel_hiz: assert property ($rose(devOe) |-> $past(readCmd, 10) || $past(readCmd, 11))
        else $error("device drives without a read");
    chk_write_oe: assert property (writeCmd |-> ##6 ctrlOe[*4])
        else $error("write beats not driven");
    chk_turn_gap: assert property (readCmd |-> ##4 !writeCmd ##4 !writeCmd)
        else $error("write too soon after read");
    chk_no_clash: assert property (!(ctrlOe && devOe))
        else $error("both ends drive the bus");
    chk_imp_step: assert property ($changed(driveCode) |->
        driveCode == $past(driveCode) + 1'h1 || driveCode == $past(driveCode) - 1'h1)
        else $error("impedance moved more than one step");

    cover property (readCmd ##4 readCmd);
    cover property (writeCmd ##4 readCmd);
    cover property (readCmd && cClk && cClkN);
    cover property ($changed(driveCode));
endmodule

/* File: verification/tb_top.sv */
// self-checking bench: controller and device ends joined over the link
`timescale 1ns/100ps
module tb_top;
    localparam int DW = 18;
    localparam int LN = 2;
    localparam int AW = 4;
    localparam int LW = DW / LN;
    logic ref_clk = 1'h0;
    logic rst_b = 1'h0;
    logic useOutClk = 1'h1;
    logic reqValid = 1'h0;
    logic reqReady;
    logic reqWrite = 1'h0;
    logic [AW-1:0] reqAddr = '0;
    logic [DW-1:0] reqData0 = '0;
    logic [DW-1:0] reqData1 = '0;
    logic [LN-1:0] reqMask0N = '1;
    logic [LN-1:0] reqMask1N = '1;
    logic rspValid;
    logic [DW-1:0] rspData0;
    logic [DW-1:0] rspData1;
    logic [4:0] impedanceReferencePin = 5'h08;
    logic [4:0] driveCode;
    logic [DW-1:0] mem [2**AW];
    logic [2*DW-1:0] expQ [$];
    logic sawFull = 1'h0;
    int errors = 0;
    int checked = 0;

    ddr_link_if #(.DATA_W(DW), .LANES(LN), .ADDR_W(AW)) link ();
    sram_ctrl_end #(.DATA_W(DW), .LANES(LN), .ADDR_W(AW)) u_sram_ctrl_end (
        .ref_clk(ref_clk), .rst_b(rst_b), .link(link.controller), .useOutClk(useOutClk),
        .reqValid(reqValid), .reqReady(reqReady), .reqWrite(reqWrite), .reqAddr(reqAddr),
        .reqData0(reqData0), .reqData1(reqData1), .reqMask0N(reqMask0N), .reqMask1N(reqMask1N),
        .rspValid(rspValid), .rspData0(rspData0), .rspData1(rspData1));
    sram_device_end #(.DATA_W(DW), .LANES(LN), .ADDR_W(AW), .HAS_A0(1'h1), .IMP_W(5)) u_sram_device_end (
        .ref_clk(ref_clk), .rst_b(rst_b), .link(link.device),
        .impedanceReferencePin(impedanceReferencePin), .driveCode(driveCode));
    sram_link_props #(.IMP_W(5)) u_sram_link_props (
        .ref_clk(ref_clk), .rst_b(rst_b), .kClk(link.kClk), .kClkN(link.kClkN), .cClk(link.cClk),
        .cClkN(link.cClkN), .commandLoadStrobeN(link.commandLoadStrobeN), .readNotWrite(link.readNotWrite),
        .ctrlOe(link.ctrlOe), .devOe(link.devOe), .driveCode(driveCode));

    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [2*DW-1:0] seen, input logic [2*DW-1:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic summarize;
        $display("checks=%0d errors=%0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic idle(input int n);
        reqValid = 1'h0;
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // leaves the request up: the caller issues again or idles in this same step
    task automatic issue(input logic wr, input logic [AW-1:0] a, input logic [DW-1:0] d0,
                         input logic [DW-1:0] d1, input logic [LN-1:0] m0, input logic [LN-1:0] m1);
        int n;
        n = 0;
        reqValid = 1'h1;
        reqWrite = wr;
        reqAddr = a;
        reqData0 = d0;
        reqData1 = d1;
        reqMask0N = m0;
        reqMask1N = m1;
        while (reqReady !== 1'h1 && n < 200) begin
            n++;
            sawFull = 1'h1;
            @(posedge ref_clk);
            #1;
        end
        if (n >= 200) check(36'h0, 36'h1);
        @(posedge ref_clk);
        #1;
        if (wr) begin
            for (int l = 0; l < LN; l++) begin
                if (!m0[l]) mem[a][l*LW +: LW] = d0[l*LW +: LW];
                if (!m1[l]) mem[a ^ AW'(1)][l*LW +: LW] = d1[l*LW +: LW];
            end
        end else begin
            expQ.push_back({mem[a], mem[a ^ AW'(1)]});
        end
    endtask

    always begin
        @(posedge ref_clk);
        #1;
        if (rspValid === 1'h1) begin
            if (expQ.size() == 0) check(36'h1, 36'h0);
            else check({rspData0, rspData1}, expQ.pop_front());
        end
    end

    initial begin
        int seed;
        logic [AW-1:0] b;
        seed = $urandom(96);
        for (int mode = 1; mode >= 0; mode--) begin
            rst_b = 1'h0;
            useOutClk = mode[0];
            repeat (20) @(posedge ref_clk);
            #1;
            rst_b = 1'h1;
            for (int a = 0; a < 2**AW; a += 2) issue(1'h1, AW'(a), DW'($urandom), DW'($urandom), '0, '0);
            // every mask pair, each read back
            for (int m = 0; m < 16; m++) begin
                b = AW'($urandom);
                issue(1'h1, b, DW'($urandom), DW'($urandom), m[1:0], m[3:2]);
                issue(1'h0, b, '0, '0, '1, '1);
            end
            sawFull = 1'h0;
            repeat (8) issue(1'h0, AW'($urandom), '0, '0, '1, '1);
            idle(80);
            check(36'(sawFull), 36'h1);
            check(36'(expQ.size()), 36'h0);
        end
        check(36'(driveCode), 36'h8);
        impedanceReferencePin = 5'h0B;
        for (int n = 0; n < 200 && driveCode === 5'h08; n++) idle(1);
        check(36'(driveCode), 36'h9);
        idle(49);
        check(36'(driveCode), 36'h9);
        idle(120);
        check(36'(driveCode), 36'hB);
        idle(60);
        check(36'(driveCode), 36'hB);
        summarize();
    end

    // generous ceiling: the planned traffic needs little more than a thousand cycles
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, 1'h0, 1'h1);
        summarize();
    end
endmodule
